// ### rtl/pcl_map.svh
// Offsets, field positions, reset values and timing counts
`ifndef PCL_MAP_SVH
`define PCL_MAP_SVH
// Register select code in address bits 19:18
`define PCL_SEL_MSB 19
`define PCL_SEL_LSB 18
`define PCL_SEL_BUS 2'b10
`define PCL_SEL_REF 2'b00
`define PCL_SEL_ID 2'b01
// Third-step data of the software sequence
`define PCL_SW_SEL_REF 16'h0000
`define PCL_SW_SEL_BUS 16'h0001
// Power-up values; identification value is arbitrary
`define PCL_BUS_RST 16'h9d1f
`define PCL_REF_RST 16'h0000
`define PCL_ID_VAL 16'h5a3c
// Refresh configuration fields
`define PCL_PAR_MSB 2
`define PCL_PAR_LSB 0
`define PCL_ANCHOR_BIT 3
`define PCL_DEEP_BIT 4
`define PCL_PAR_FULL 3'h0
`define PCL_PAR_HALF 3'h1
`define PCL_PAR_QUART 3'h2
`define PCL_PAR_EIGHTH 3'h3
`define PCL_PAR_NONE 3'h4
// Bus configuration fields used here
`define PCL_ASYNC_BIT 15
`define PCL_WAIT_POL_BIT 10
// Timing
`define PCL_CLK_MHZ 100
`define PCL_WAKE_US 10
`define PCL_WAKE_CYC (`PCL_WAKE_US * `PCL_CLK_MHZ)
`define PCL_INIT_US 150
`define PCL_INIT_CYC (`PCL_INIT_US * `PCL_CLK_MHZ)
`define PCL_IDLE_US 2
`define PCL_IDLE_CYC (`PCL_IDLE_US * `PCL_CLK_MHZ)
`endif

// ### rtl/pcl_pkg.sv
// Types shared by the configuration and low-power control
package pcl_pkg;
   // Software access sequence progress
   typedef enum logic [1:0] {
      sw_idle = 2'b00,
      sw_r1 = 2'b01,
      sw_r2 = 2'b11,
      sw_w3 = 2'b10
   } pcl_sw_e;
   // Power state
   typedef enum logic [1:0] {
      pw_run = 2'b00,
      pw_sleep = 2'b01,
      pw_wake = 2'b11,
      pw_init = 2'b10
   } pcl_pw_e;
endpackage

// ### rtl/pcl_ctrl.sv
// Configuration register access and low-power control
// Summary of operation
// - Chip select high puts the device in standby, refresh only.
// - Reduced power after an access or long idle bus inputs; a bus input change wakes, except the first change after a long idle.
// - Self-refresh rate follows the on-chip temperature reading.
// - Partial refresh covers all, half, quarter, eighth or none, bottom/top.
// - Refreshed regions work normally; unrefreshed ones lose data.
// - A region added by a refresh write is usable right after it.
// - Deep sleep stops all refresh, so contents are lost.
// - Leaving deep sleep runs a 150 us initialization before normal use.
// - Refresh write arms deep sleep; it starts at next chip select rise.
// - Deep sleep ends once chip select stays low for 10 us.
// - Both configuration registers load defaults at reset.
// - Identification register reports fixed data and ignores writes.
// - Register-space input high targets registers, low targets the array.
// - Register write value comes from the muxed lines; upper address selects.
// - Async register write captured at first rise of valid, select, write.
// - Bits 19:18 select: 10 bus, 00 refresh, 01 identification.
// - Register read ignores other address bits, drives all sixteen bits.
// - Software access: two reads, then write and write or read.
// - Software sequence uses the top address and leaves it unchanged.
// - Third write 0000h picks refresh, 0001h bus; fourth moves data.
// - Sync access colliding with refresh holds WAIT until refresh ends.
`timescale 1ns/100ps
`include "pcl_map.svh"
module pcl_ctrl #(
   parameter int unsigned P_INIT_CYC = `PCL_INIT_CYC
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce_n,
   input wire logic i_addr_valid_n,
   input wire logic i_oe_n,
   input wire logic i_we_n,
   input wire logic i_reg_space_select,
   input wire logic [7:0] i_addr_hi,
   input wire logic [15:0] i_muxed_addr_data_i,
   input wire logic [1:0] i_temp_code,
   input wire logic i_refresh_busy,
   output logic [15:0] o_muxed_addr_data_o,
   output logic o_muxed_addr_data_oe,
   output logic o_wait,
   output logic o_wait_oe,
   output logic o_array_select,
   output logic o_array_write_inhibit,
   output logic o_standby,
   output logic o_low_power,
   output logic o_deep_sleep,
   output logic o_init_busy,
   output logic [1:0] o_refresh_rate,
   output logic [7:0] o_refresh_mask,
   output logic [15:0] o_bus_configuration,
   output logic [15:0] o_refresh_configuration
);
   // ****************************************
   // Pin synchronisers and edge detection
   // ****************************************
   localparam logic [30:0] PIN_IDLE = 31'h78000000;
   logic [30:0] sy1, sy2, pv;
   logic ce_n, adv_n, oe_n, we_n, reg_space_select, p_ce, p_adv, p_we, p_cre;
   logic ce_rise, adv_rise, we_rise;
   logic [23:0] cur_addr, p_addr, lat;
   logic [1:0] temp;

   // Two stages, then one more for edges
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         sy1 <= PIN_IDLE;
         sy2 <= PIN_IDLE;
         pv <= PIN_IDLE;
      end else begin
         sy1 <= {i_ce_n, i_addr_valid_n, i_oe_n, i_we_n, i_reg_space_select,
                 i_addr_hi, i_muxed_addr_data_i, i_temp_code};
         sy2 <= sy1;
         pv <= sy2;
      end
   end

   // Field split of the synchronised pins
   assign {ce_n, adv_n, oe_n, we_n, reg_space_select, cur_addr, temp} = sy2;
   assign {p_ce, p_adv} = pv[30:29];
   assign {p_we, p_cre} = pv[27:26];
   assign p_addr = pv[25:2];
   assign ce_rise = ce_n & ~p_ce;
   assign adv_rise = adv_n & ~p_adv;
   assign we_rise = we_n & ~p_we;

   // Address latch follows the bus while address valid is low
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         lat <= 24'h000000;
      end else if (!ce_n && !adv_n) begin
         lat <= cur_addr;
      end
   end

   // ****************************************
   // Register state
   // ****************************************
   logic [15:0] bus_cfg, ref_cfg, next_bus, next_ref, wdat;
   logic cre_ev, cre_done, sw_ev, wake_done, init_done;
   logic [1:0] sw_sel;
   pcl_pkg::pcl_sw_e st;
   pcl_pkg::pcl_pw_e pw;

   // Selected register contents
   function automatic logic [15:0] pcl_pick(input logic [1:0] s,
      input logic [15:0] b, input logic [15:0] r);
      logic [15:0] v;
      v = 16'h0000;
      unique case (s)
         `PCL_SEL_BUS: v = b;
         `PCL_SEL_REF: v = r;
         `PCL_SEL_ID: v = `PCL_ID_VAL;
         default: v = 16'h0000;
      endcase
      return v;
   endfunction

   // First rising edge of valid, select or write ends a register write
   assign cre_ev = p_cre && !p_ce && !p_we && !cre_done &&
                   (adv_rise || ce_rise || we_rise);

   // One capture per register write
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || ce_n) begin
         cre_done <= 1'b0;
      end else if (cre_ev) begin
         cre_done <= 1'b1;
      end
   end

   // Next register values; software write wins over the hardware clear
   always_comb begin
      next_bus = bus_cfg;
      next_ref = ref_cfg;
      if (pw == pcl_pkg::pw_wake && wake_done) begin
         next_ref[`PCL_DEEP_BIT] = 1'b0;
      end
      if (cre_ev) begin
         if (p_addr[`PCL_SEL_MSB:`PCL_SEL_LSB] == `PCL_SEL_BUS) begin
            next_bus = p_addr[15:0];
         end else if (p_addr[`PCL_SEL_MSB:`PCL_SEL_LSB] == `PCL_SEL_REF) begin
            next_ref = p_addr[15:0];
         end
      end else if (sw_ev) begin
         if (sw_sel == `PCL_SEL_BUS) begin
            next_bus = wdat;
         end else begin
            next_ref = wdat;
         end
      end
   end

   // Configuration registers with power-up defaults
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         bus_cfg <= `PCL_BUS_RST;
         ref_cfg <= `PCL_REF_RST;
      end else begin
         bus_cfg <= next_bus;
         ref_cfg <= next_ref;
      end
   end

   // ****************************************
   // Software access sequence
   // ****************************************
   logic op_wr, op_cre, ok_rd, ok_wr, rd_cre, rd_sw;

   // Kind of the access under way
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || (!ce_n && p_ce)) begin
         op_wr <= 1'b0;
         op_cre <= 1'b0;
      end else if (!ce_n) begin
         op_wr <= op_wr | ~we_n;
         op_cre <= op_cre | reg_space_select;
      end
   end

   // Write data of the data phase
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         wdat <= 16'h0000;
      end else if (!ce_n && !we_n && adv_n) begin
         wdat <= cur_addr[15:0];
      end
   end

   assign ok_rd = (&lat) && !op_wr && !op_cre;
   assign ok_wr = (&lat) && op_wr && !op_cre;
   assign sw_ev = ce_rise && st == pcl_pkg::sw_w3 && ok_wr;

   // Sequence tracker, abandoned by any other access
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         st <= pcl_pkg::sw_idle;
         sw_sel <= `PCL_SEL_REF;
      end else if (ce_rise) begin
         unique case (st)
            pcl_pkg::sw_idle: st <= ok_rd ? pcl_pkg::sw_r1 : pcl_pkg::sw_idle;
            pcl_pkg::sw_r1: st <= ok_rd ? pcl_pkg::sw_r2 : pcl_pkg::sw_idle;
            pcl_pkg::sw_r2: begin
               if (ok_wr && (wdat == `PCL_SW_SEL_REF ||
                             wdat == `PCL_SW_SEL_BUS)) begin
                  st <= pcl_pkg::sw_w3;
                  sw_sel <= wdat[0] ? `PCL_SEL_BUS : `PCL_SEL_REF;
               end else begin
                  st <= pcl_pkg::sw_idle;
               end
            end
            pcl_pkg::sw_w3: st <= pcl_pkg::sw_idle;
         endcase
      end
   end

   // ****************************************
   // Data output and array steering
   // ****************************************
   assign rd_cre = !ce_n && we_n && !oe_n && reg_space_select && adv_n;
   assign rd_sw = st == pcl_pkg::sw_w3 && !ce_n && we_n && !oe_n &&
                  !reg_space_select && adv_n && (&lat);

   // Register read data and array control
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_muxed_addr_data_o <= 16'h0000;
         o_muxed_addr_data_oe <= 1'b0;
         o_array_select <= 1'b0;
         o_array_write_inhibit <= 1'b0;
      end else begin
         o_muxed_addr_data_oe <= rd_cre | rd_sw;
         if (rd_cre) begin
            o_muxed_addr_data_o <= pcl_pick(lat[`PCL_SEL_MSB:`PCL_SEL_LSB],
                                            bus_cfg, ref_cfg);
         end else if (rd_sw) begin
            o_muxed_addr_data_o <= pcl_pick(sw_sel, bus_cfg, ref_cfg);
         end else begin
            o_muxed_addr_data_o <= 16'h0000;
         end
         o_array_select <= !ce_n && !reg_space_select && !rd_sw &&
                           pw == pcl_pkg::pw_run;
         o_array_write_inhibit <= !ce_n && !we_n && !reg_space_select && (&lat) &&
            (st == pcl_pkg::sw_r2 || st == pcl_pkg::sw_w3);
      end
   end

   // ****************************************
   // Standby, reduced power and refresh
   // ****************************************
   logic [7:0] idle_cnt;
   logic chg;
   assign chg = sy2[30:2] != pv[30:2];

   // Partial refresh eighths, mirrored when anchored at the top
   function automatic logic [7:0] pcl_mask(input logic [2:0] par,
      input logic top);
      logic [7:0] m, r;
      m = 8'hff;
      unique case (par)
         `PCL_PAR_HALF: m = 8'h0f;
         `PCL_PAR_QUART: m = 8'h03;
         `PCL_PAR_EIGHTH: m = 8'h01;
         `PCL_PAR_NONE: m = 8'h00;
         default: m = 8'hff;
      endcase
      r = m;
      if (top) begin
         for (int i = 0; i < 8; i++) begin
            r[i] = m[7 - i];
         end
      end
      return r;
   endfunction

   // Idle counter restarts on any bus input change
   always_ff @(posedge i_clk) begin
      if (!i_rst_n || chg) begin
         idle_cnt <= 8'h00;
      end else if (idle_cnt != 8'(`PCL_IDLE_CYC - 1)) begin
         idle_cnt <= idle_cnt + 8'h01;
      end
   end

   // Power indications; completion wins over change
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_standby <= 1'b1;
         o_low_power <= 1'b0;
         o_refresh_rate <= 2'h0;
         o_refresh_mask <= 8'hff;
      end else begin
         o_standby <= ce_n;
         if (ce_rise || idle_cnt == 8'(`PCL_IDLE_CYC - 1)) begin
            o_low_power <= 1'b1;
         end else if (chg) begin
            o_low_power <= 1'b0;
         end
         o_refresh_rate <= temp;
         if (pw == pcl_pkg::pw_sleep || pw == pcl_pkg::pw_wake) begin
            o_refresh_mask <= 8'h00;
         end else begin
            o_refresh_mask <= pcl_mask(ref_cfg[`PCL_PAR_MSB:`PCL_PAR_LSB],
               ref_cfg[`PCL_ANCHOR_BIT]);
         end
      end
   end

   // WAIT during a synchronous access that meets a refresh
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_wait <= 1'b0;
         o_wait_oe <= 1'b0;
      end else begin
         o_wait_oe <= !ce_n && !bus_cfg[`PCL_ASYNC_BIT];
         o_wait <= (i_refresh_busy && !ce_n && !bus_cfg[`PCL_ASYNC_BIT]) ==
                   bus_cfg[`PCL_WAIT_POL_BIT];
      end
   end

   // ****************************************
   // Deep sleep entry, wake and initialization
   // ****************************************
   logic [13:0] cnt;
   assign wake_done = !ce_n && cnt == 14'(`PCL_WAKE_CYC - 1);
   assign init_done = cnt == 14'(P_INIT_CYC - 1);

   // Power state machine
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         pw <= pcl_pkg::pw_run;
      end else begin
         unique case (pw)
            pcl_pkg::pw_run: if (ce_rise && next_ref[`PCL_DEEP_BIT]) begin
               pw <= pcl_pkg::pw_sleep;
            end
            pcl_pkg::pw_sleep: if (!ce_n) begin
               pw <= pcl_pkg::pw_wake;
            end
            pcl_pkg::pw_wake: if (ce_n) begin
               pw <= pcl_pkg::pw_sleep;
            end else if (wake_done) begin
               pw <= pcl_pkg::pw_init;
            end
            pcl_pkg::pw_init: if (init_done) begin
               pw <= pcl_pkg::pw_run;
            end
         endcase
      end
   end

   // Wake and initialization timer
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         cnt <= 14'h0000;
      end else if ((pw == pcl_pkg::pw_wake && !ce_n && !wake_done) ||
                   (pw == pcl_pkg::pw_init && !init_done)) begin
         cnt <= cnt + 14'h0001;
      end else begin
         cnt <= 14'h0000;
      end
   end

   // State outputs
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         o_deep_sleep <= 1'b0;
         o_init_busy <= 1'b0;
         o_bus_configuration <= `PCL_BUS_RST;
         o_refresh_configuration <= `PCL_REF_RST;
      end else begin
         o_deep_sleep <= pw == pcl_pkg::pw_sleep || pw == pcl_pkg::pw_wake;
         o_init_busy <= pw == pcl_pkg::pw_init;
         o_bus_configuration <= bus_cfg;
         o_refresh_configuration <= ref_cfg;
      end
   end

   // ****************************************
   // Checks
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   chk_standby_pin: assert property (##4 (o_standby == $past(i_ce_n, 3)))
      else $error("standby does not follow chip select");
   chk_low_power_end: assert property (ce_rise |=> o_low_power)
      else $error("no reduced power after access");
   chk_temp_rate: assert property (##4
      (o_refresh_rate == $past(i_temp_code, 3)))
      else $error("refresh rate not from temperature");
   chk_par_half: assert property (cre_ev && p_addr[19:18] == 2'b00 &&
      p_addr[4:0] == 5'h01 && pw == pcl_pkg::pw_run
      |-> ##2 o_refresh_mask == 8'h0f)
      else $error("half refresh mask wrong");
   chk_deep_mask: assert property (o_deep_sleep |-> o_refresh_mask == 8'h00)
      else $error("refresh during deep sleep");
   chk_deep_entry: assert property (pw == pcl_pkg::pw_run && ce_rise &&
      next_ref[`PCL_DEEP_BIT] |-> ##2 o_deep_sleep)
      else $error("deep sleep not entered");
   chk_wake_abort: assert property (pw == pcl_pkg::pw_wake && ce_n
      |=> pw == pcl_pkg::pw_sleep)
      else $error("woke with short low pulse");
   chk_init_hold: assert property ($rose(o_init_busy) |-> o_init_busy[*8])
      else $error("initialization ended early");
   chk_id_ignored: assert property (cre_ev && p_addr[19:18] == 2'b01
      |=> $stable(bus_cfg) && $stable(ref_cfg))
      else $error("identification write changed state");
   chk_bus_write: assert property (cre_ev && p_addr[19:18] == 2'b10
      |=> bus_cfg == $past(p_addr[15:0]))
      else $error("bus configuration write lost");
   chk_reg_read: assert property (rd_cre && lat[19:18] == 2'b01 |=>
      o_muxed_addr_data_oe && o_muxed_addr_data_o == `PCL_ID_VAL)
      else $error("identification read wrong");
   chk_sw_write: assert property (sw_ev && sw_sel == 2'b00 |=> ref_cfg ==
      $past(wdat))
      else $error("software write lost");
   chk_top_inhibit: assert property (st == pcl_pkg::sw_w3 && !ce_n && !we_n
      && !reg_space_select && (&lat) |=> o_array_write_inhibit)
      else $error("top location written by sequence");
   chk_wait_coll: assert property (i_refresh_busy && !ce_n &&
      !bus_cfg[15] |=> o_wait_oe && o_wait == $past(bus_cfg[10]))
      else $error("WAIT missing on collision");

   cov_deep_cycle: cover property ($fell(o_init_busy));
   cov_sw_load: cover property (sw_ev);
   cov_cre_read: cover property (rd_cre ##1 o_muxed_addr_data_oe);
endmodule // pcl_ctrl

// ### dv/pcl_host_model.sv
// Memory controller model that drives the device pins with async operations
`timescale 1ns/100ps
module pcl_host_model (
   input wire logic i_clk,
   input wire logic [15:0] i_data,
   input wire logic i_data_oe,
   output logic o_ce_n,
   output logic o_adv_n,
   output logic o_oe_n,
   output logic o_we_n,
   output logic o_cre,
   output logic [7:0] o_addr,
   output logic [15:0] o_adq
);
   // Idle bus at time zero
   initial begin
      o_ce_n = 1'b1;
      o_adv_n = 1'b1;
      o_oe_n = 1'b1;
      o_we_n = 1'b1;
      o_cre = 1'b0;
      o_addr = 8'h00;
      o_adq = 16'h0000;
   end
   // Wait n falling edges; pins change only there
   task automatic hold(input int n);
      repeat (n) @(negedge i_clk);
   endtask
   // One async operation, released by chip select rise
   task automatic op(input logic reg_space_select, input logic wr, input logic [7:0] a,
         input logic [15:0] ad, input logic [15:0] d,
         output logic [15:0] q);
      @(negedge i_clk);
      o_ce_n = 1'b0;
      o_cre = reg_space_select;
      o_we_n = ~wr;
      o_adv_n = 1'b0;
      o_addr = a;
      o_adq = ad;
      hold(4);
      o_adv_n = 1'b1;
      if (wr) begin
         o_adq = d;
      end else begin
         o_oe_n = 1'b0;
      end
      hold(5);
      q = i_data_oe ? i_data : 16'hxxxx;
      o_ce_n = 1'b1;
      o_we_n = 1'b1;
      o_oe_n = 1'b1;
      o_cre = 1'b0;
      o_adq = ~o_adq; // Released lines do not keep the last value
      hold(5);
   endtask
   // Chip select low for n cycles with no access
   task automatic ce_low(input int n);
      @(negedge i_clk);
      o_ce_n = 1'b0;
      hold(n);
      o_ce_n = 1'b1;
      hold(5);
   endtask
endmodule // pcl_host_model

// ### dv/pcl_ctrl_tb_top.sv
// Self-checking bench for the configuration and low-power control
`timescale 1ns/100ps
`include "pcl_map.svh"
module pcl_ctrl_tb_top;
   localparam int unsigned INIT = 50;
   typedef struct {
      logic [1:0] ws;
      logic [15:0] wv;
      logic [1:0] rs;
      logic [15:0] rx;
      logic [7:0] mx;
   } pcl_row_s;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic ce_n, adv_n, oe_n, we_n, reg_space_select, rbusy, doe, wt, wt_oe, stby, lp;
   logic deep, ibusy, asel, winh;
   logic [1:0] temp, rate;
   logic [7:0] ahi, mask;
   logic [15:0] muxed_addr_data, dout, bus, refr, q;
   int err_count = 0;
   int total_checks = 0;
   int k;
   pcl_row_s rows[12];
   // ****************
   // Clock, model, design
   // ****************
   always #5 clk = ~clk;
   pcl_host_model host (.i_clk(clk), .i_data(dout), .i_data_oe(doe),
      .o_ce_n(ce_n), .o_adv_n(adv_n), .o_oe_n(oe_n), .o_we_n(we_n),
      .o_cre(reg_space_select), .o_addr(ahi), .o_adq(muxed_addr_data));
   pcl_ctrl #(.P_INIT_CYC(INIT)) dut (.i_clk(clk), .i_rst_n(rst_n),
      .i_ce_n(ce_n), .i_addr_valid_n(adv_n), .i_oe_n(oe_n), .i_we_n(we_n),
      .i_reg_space_select(reg_space_select), .i_addr_hi(ahi), .i_muxed_addr_data_i(muxed_addr_data),
      .i_temp_code(temp), .i_refresh_busy(rbusy),
      .o_muxed_addr_data_o(dout), .o_muxed_addr_data_oe(doe), .o_wait(wt),
      .o_wait_oe(wt_oe), .o_array_select(asel), .o_array_write_inhibit(winh),
      .o_standby(stby), .o_low_power(lp), .o_deep_sleep(deep),
      .o_init_busy(ibusy), .o_refresh_rate(rate), .o_refresh_mask(mask),
      .o_bus_configuration(bus), .o_refresh_configuration(refr));
   // ****************
   // Checking and closing
   // ****************
   task automatic check(input string nm, input logic [15:0] seen,
         input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("Checks made %0d, mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // Software sequence of four operations at the top address, second one at upper byte a2
   task automatic sw(input logic [7:0] a2, input logic w4,
         input logic [15:0] d3, input logic [15:0] d4, input logic ih);
      host.op(1'b0, 1'b0, 8'hff, 16'hffff, 16'h0000, q);
      host.op(1'b0, 1'b0, a2, 16'hffff, 16'h0000, q);
      fork
         host.op(1'b0, 1'b1, 8'hff, 16'hffff, d3, q);
         begin
            host.hold(7);
            check("inhibit", {15'h0, winh}, {15'h0, ih});
         end
      join
      host.op(1'b0, w4, 8'hff, 16'hffff, d4, q);
   endtask
   // Global bound on run length
   initial begin
      repeat (100000) @(posedge clk);
      err_count++;
      conclude();
   end
   // ****************
   // Main sequence
   // ****************
   initial begin
      temp = 2'b00;
      rbusy = 1'b0;
      rows = '{'{2'b00, 16'h0000, 2'b00, 16'h0000, 8'hff},
               '{2'b00, 16'h0001, 2'b00, 16'h0001, 8'h0f},
               '{2'b00, 16'h0002, 2'b00, 16'h0002, 8'h03},
               '{2'b00, 16'h0003, 2'b00, 16'h0003, 8'h01},
               '{2'b00, 16'h0004, 2'b00, 16'h0004, 8'h00},
               '{2'b00, 16'h0009, 2'b00, 16'h0009, 8'hf0},
               '{2'b00, 16'h000a, 2'b00, 16'h000a, 8'hc0},
               '{2'b00, 16'h000b, 2'b00, 16'h000b, 8'h80},
               '{2'b10, 16'h1234, 2'b10, 16'h1234, 8'h80},
               '{2'b01, 16'hffff, 2'b01, `PCL_ID_VAL, 8'h80},
               '{2'b11, 16'h7777, 2'b11, 16'h0000, 8'h80},
               '{2'b00, 16'h0000, 2'b00, 16'h0000, 8'hff}};
      repeat (20) @(negedge clk);
      check("bus reset", bus, `PCL_BUS_RST);
      check("ref reset", refr, `PCL_REF_RST);
      check("mask reset", {8'h00, mask}, 16'h00ff);
      rst_n = 1'b1;
      host.hold(3);
      $display("Reset test done");
      // Register writes and reads through the register-space input
      foreach (rows[i]) begin
         host.op(1'b1, 1'b1, {4'h5, rows[i].ws, 2'b11}, rows[i].wv,
            rows[i].wv, q);
         host.op(1'b1, 1'b0, {4'ha, rows[i].rs, 2'b01}, 16'h5a5a,
            16'h0000, q);
         check("reg read", q, rows[i].rx);
         fork
            host.op(1'b0, 1'b0, 8'h00, 16'h0000, 16'h0000, q);
            begin
               host.hold(6);
               check("arr", {13'h0, stby, lp, asel}, 16'h0001);
            end
         join
         check("mask", {8'h00, mask}, {8'h00, rows[i].mx});
      end
      $display("Register table test done");
      check("standby", {15'h0, stby}, 16'h0001);
      check("low power", {15'h0, lp}, 16'h0001);
      // WAIT in sync mode, active low after bus write 1234
      rbusy = 1'b1;
      fork
         host.ce_low(12);
         begin
            host.hold(6);
            check("wait on", {14'h0, wt_oe, wt}, 16'h0002);
            rbusy = 1'b0;
            host.hold(3);
            check("wait off", {14'h0, wt_oe, wt}, 16'h0003);
         end
      join
      $display("Wait test done");
      for (int t = 0; t < 4; t++) begin
         temp = t[1:0];
         host.hold(5);
         check("rate", {14'h0, rate}, {14'h0, temp});
      end
      $display("Temperature test done");
      sw(8'hff, 1'b1, `PCL_SW_SEL_BUS, 16'h4321, 1'b1);
      check("sw load", bus, 16'h4321);
      sw(8'hff, 1'b0, `PCL_SW_SEL_BUS, 16'h0000, 1'b1);
      check("sw read", q, 16'h4321);
      sw(8'h00, 1'b1, `PCL_SW_SEL_BUS, 16'h5555, 1'b0);
      check("sw abandon", bus, 16'h4321);
      $display("Software sequence test done");
      // Deep sleep: arm, enter on chip select rise, wake, initialize
      host.op(1'b1, 1'b1, 8'h00, 16'h0010, 16'h0010, q);
      check("deep on", {15'h0, deep}, 16'h0001);
      check("deep mask", {8'h00, mask}, 16'h0000);
      // A short chip select low must not wake the device
      host.ce_low(20);
      check("short wake", {15'h0, deep}, 16'h0001);
      fork
         host.ce_low(1010);
         begin
            host.hold(900);
            check("still deep", {15'h0, deep}, 16'h0001);
         end
      join
      check("deep off", {15'h0, deep}, 16'h0000);
      check("init busy", {15'h0, ibusy}, 16'h0001);
      k = 0;
      while (ibusy !== 1'b0 && k < INIT + 20) begin
         host.hold(1);
         k++;
      end
      if (k >= INIT + 20) begin
         err_count++;
         conclude();
      end
      check("arm cleared", refr, 16'h0000);
      $display("Deep sleep test done");
      conclude();
   end
endmodule // pcl_ctrl_tb_top
